// [logic/delay_timer.v]
module delay_timer (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       start,
  input  wire [8:0] ticks,
  input  wire       tick,
  output wire       running,
  output reg        done
);
  reg [8:0] cnt_reg;

  assign running = (cnt_reg != 9'h000);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 9'h000;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_reg <= ticks;
      end else if (running && tick) begin
        cnt_reg <= cnt_reg - 9'h001;
        if (cnt_reg == 9'h001) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule // delay_timer

// [logic/fdc_map.vh]
// What this block does
// - Interrupt on entering result phase of any read, write, format or verify command.
// - Interrupt when seek, relative seek or recalibrate ends, normally or abnormally.
// - Without DMA, interrupt whenever an execution-phase data byte needs host transfer.
// - Interrupt sense clears pending interrupt and returns status zero with cause.
// - Cause codes: flag 0 code 11 polling; flag 1 code 00 normal; 01 abnormal.
// - Head address bit of returned status zero always reads zero.
// - Drive stays busy until interrupt sense follows its positioning operation.
// - Drive status sense skips execution and returns drive status at once.
// - Specify loads unload delay, step interval and load delay.
// - Head unloads after unload delay counted from read/write execution end.
// - Step pulses spaced by step interval; first gap may be shorter.
// - Read/write starts only after load delay from head load going high.
// - All three delays scale with data rate; same for FM and MFM.
// - Transfer-mode bit 1 selects non-DMA, 0 selects DMA.
`ifndef FDC_MAP_VH
`define FDC_MAP_VH
`define OFS_CMD        12'h000
`define OFS_SPECIFY    12'h004
`define OFS_RATE       12'h008
`define OFS_RESULT     12'h00c
`define OFS_STATUS     12'h010
`define OFS_MASK       12'h014
`define OFS_STATE      12'h018
`define CMD_SENSE_INT  4'h1
`define CMD_SENSE_DRV  4'h2
`define SPEC_SRT_LSB   0
`define SPEC_HUT_LSB   4
`define SPEC_HLT_LSB   8
`define SPEC_ND_BIT    15
`define SPEC_RESET     16'h0000
`define RATE_1M        2'b00
`define RATE_500K      2'b01
`define RATE_300K      2'b10
`define RATE_250K      2'b11
`define CAUSE_NORMAL   2'b00
`define CAUSE_ABNORMAL 2'b01
`define CAUSE_INVALID  2'b10
`define CAUSE_POLL     2'b11
`define EV_RW_RESULT   0
`define EV_POS_END     1
`define EV_XFER_REQ    2
`define EV_POLL        3
`define CLK_PERIOD_NS  4
`define BASE_TICK_NS   500000
`define BASE_TICK_CYC  (`BASE_TICK_NS / `CLK_PERIOD_NS)
`define HUT_TICKS_PER  16
`define HLT_TICKS_PER  2
`define HUT_ZERO_UNITS 16
`define HLT_ZERO_UNITS 128
`define SRT_SPAN       16
`endif

// [logic/fdc_sense_specify.v]
// The APB register port and the address map are this design's own decisions.
`include "fdc_map.vh"
module fdc_sense_specify #(
  parameter BASE_CYC = `BASE_TICK_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        rw_result_enter,
  input  wire        pos_start,
  input  wire        pos_end,
  input  wire        pos_abnormal,
  input  wire [1:0]  pos_drive,
  input  wire [7:0]  pos_cylinder,
  input  wire        xfer_byte_req,
  input  wire        xfer_byte_done,
  input  wire        poll_event,
  input  wire [7:0]  drive_status,
  input  wire        rw_exec_end,
  input  wire        head_load_req,
  input  wire        step_request,
  output reg         controller_irq_pin,
  output wire        irq,
  output reg         head_load_out,
  output reg         rw_start_ok,
  output reg         step_pulse,
  output wire        non_dma_select,
  output reg  [3:0]  drive_busy
);
  reg  [15:0] spec_reg;
  reg  [1:0]  rate_reg;
  reg  [3:0]  status_reg;
  reg  [3:0]  mask_reg;
  reg  [15:0] result_reg;
  reg         result_valid_reg;
  reg         pend_reg;
  reg  [1:0]  pend_code_reg;
  reg         pend_flag_reg;
  reg  [1:0]  pend_drive_reg;
  reg  [7:0]  pend_cyl_reg;
  reg         xfer_pend_reg;
  reg  [3:0]  status_next;
  wire        wr_acc;
  wire        rd_setup;
  wire        mapped;
  wire        tick;
  wire [3:0]  step_interval;
  wire [3:0]  unload_delay;
  wire [6:0]  load_delay;
  wire [8:0]  unload_ticks;
  wire [8:0]  step_ticks;
  wire [8:0]  load_ticks;
  wire        unload_done;
  wire        load_done;
  wire        step_running;
  wire        step_fire;
  wire        sense_int_cmd;
  wire        sense_drv_cmd;
  wire [3:0]  events;
  wire [7:0]  result_reg_zero;
  wire [1:0]  cause_code_field;
  wire        positioning_complete_flag;
  wire [7:0]  current_cylinder;
  wire [31:0] unload_prod;
  wire [31:0] load_prod;
  wire [31:0] step_diff;

  // Counts are built at full width and cut on purpose to the nine-bit timer load.
  localparam [31:0] UNLOAD_MAX = `HUT_ZERO_UNITS * `HUT_TICKS_PER;
  localparam [31:0] LOAD_MAX   = `HLT_ZERO_UNITS * `HLT_TICKS_PER;

  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `OFS_CMD) || (a == `OFS_SPECIFY) || (a == `OFS_RATE) ||
                  (a == `OFS_RESULT) || (a == `OFS_STATUS) || (a == `OFS_MASK) ||
                  (a == `OFS_STATE);
    end
  endfunction

  assign mapped   = is_mapped(paddr);
  // Zero wait states: every access phase completes, and unmapped offsets flag an error instead.
  assign pready   = psel & penable;
  assign pslverr  = psel & penable & ~mapped;
  assign wr_acc   = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;

  // Commands are single writes; the result is ready for the very next transfer.
  assign sense_int_cmd = wr_acc && (paddr == `OFS_CMD) && (pwdata[3:0] == `CMD_SENSE_INT);
  assign sense_drv_cmd = wr_acc && (paddr == `OFS_CMD) && (pwdata[3:0] == `CMD_SENSE_DRV);

  assign step_interval  = spec_reg[`SPEC_SRT_LSB +: 4];
  assign unload_delay   = spec_reg[`SPEC_HUT_LSB +: 4];
  assign load_delay     = spec_reg[`SPEC_HLT_LSB +: 7];
  assign non_dma_select = spec_reg[`SPEC_ND_BIT];

  // Delays in ticks of half a millisecond at the top rate; a zero code means the longest delay.
  assign unload_prod  = unload_delay * `HUT_TICKS_PER;
  assign load_prod    = load_delay * `HLT_TICKS_PER;
  assign step_diff    = `SRT_SPAN - step_interval;
  assign unload_ticks = (unload_delay == 4'h0) ? UNLOAD_MAX[8:0] : unload_prod[8:0];
  assign step_ticks   = step_diff[8:0];
  assign load_ticks   = (load_delay == 7'h00) ? LOAD_MAX[8:0] : load_prod[8:0];

  rate_tick #(
    .BASE_CYC (BASE_CYC)
  ) u_tick (
    .pclk     (pclk),
    .presetn  (presetn),
    .rate_sel (rate_reg),
    .tick     (tick)
  );

  // The unload countdown restarts on every read/write end, so back-to-back commands keep the head loaded.
  delay_timer u_unload (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (rw_exec_end),
    .ticks   (unload_ticks),
    .tick    (tick),
    .running (),
    .done    (unload_done)
  );

  delay_timer u_load (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (head_load_req & ~head_load_out),
    .ticks   (load_ticks),
    .tick    (tick),
    .running (),
    .done    (load_done)
  );

  delay_timer u_step (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (step_fire),
    .ticks   (step_ticks),
    .tick    (tick),
    .running (step_running),
    .done    ()
  );

  // A new pulse waits for the interval timer to drain; the free tick can make the first gap short.
  assign step_fire = step_request & ~step_running & ~step_pulse;

  // The start gate only opens while the head is still loaded.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_pulse    <= 1'b0;
      head_load_out <= 1'b0;
      rw_start_ok   <= 1'b0;
    end else begin
      step_pulse <= step_fire;
      if (head_load_req && !head_load_out) begin
        head_load_out <= 1'b1;
        rw_start_ok   <= 1'b0;
      end else if (unload_done) begin
        head_load_out <= 1'b0;
        rw_start_ok   <= 1'b0;
      end else if (load_done && head_load_out) begin
        rw_start_ok <= 1'b1;
      end
    end
  end

  // Sticky event bits; a new event wins over a write-one clear in the same cycle.
  assign events[`EV_RW_RESULT] = rw_result_enter;
  assign events[`EV_POS_END]   = pos_end;
  assign events[`EV_XFER_REQ]  = xfer_byte_req & non_dma_select;
  assign events[`EV_POLL]      = poll_event;

  always @* begin
    status_next = status_reg;
    if (wr_acc && paddr == `OFS_STATUS) begin
      status_next = status_reg & ~pwdata[3:0];
    end
    status_next = status_next | events;
  end

  // The level output follows the sticky bits, so masking a bit hides it without losing it.
  assign irq = |(status_reg & mask_reg);

  // Pending cause for the sense command; positioning end outranks polling.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg       <= 1'b0;
      pend_code_reg  <= `CAUSE_INVALID;
      pend_flag_reg  <= 1'b0;
      pend_drive_reg <= 2'b00;
      pend_cyl_reg   <= 8'h00;
    end else if (pos_end) begin
      pend_reg       <= 1'b1;
      pend_flag_reg  <= 1'b1;
      pend_code_reg  <= pos_abnormal ? `CAUSE_ABNORMAL : `CAUSE_NORMAL;
      pend_drive_reg <= pos_drive;
      pend_cyl_reg   <= pos_cylinder;
    end else if (poll_event && !(pend_reg && pend_flag_reg)) begin
      pend_reg      <= 1'b1;
      pend_flag_reg <= 1'b0;
      pend_code_reg <= `CAUSE_POLL;
    end else if (sense_int_cmd) begin
      pend_reg <= 1'b0;
    end
  end

  assign cause_code_field          = pend_reg ? pend_code_reg : `CAUSE_INVALID;
  assign positioning_complete_flag = pend_reg & pend_flag_reg;
  assign current_cylinder          = pend_cyl_reg;
  assign result_reg_zero = {cause_code_field, positioning_complete_flag, 2'b00, 1'b0,
                            pend_drive_reg};

  // A non-DMA byte request keeps the pin up until the host moves the byte.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_pend_reg      <= 1'b0;
      controller_irq_pin <= 1'b0;
    end else begin
      if (events[`EV_XFER_REQ]) begin
        xfer_pend_reg <= 1'b1;
      end else if (xfer_byte_done) begin
        xfer_pend_reg <= 1'b0;
      end
      // Held from the event until serviced; result-phase entries are held by the pin's own feedback term.
      controller_irq_pin <= (pend_reg & ~sense_int_cmd) | events[`EV_RW_RESULT] | pos_end |
                            poll_event | events[`EV_XFER_REQ] |
                            (xfer_pend_reg & ~xfer_byte_done) |
                            (controller_irq_pin & ~sense_int_cmd & ~xfer_byte_done);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_busy <= 4'h0;
    end else begin
      // The set comes last, so a start on the drive being cleared still marks it busy.
      if (sense_int_cmd && positioning_complete_flag) begin
        drive_busy[pend_drive_reg] <= 1'b0;
      end
      if (pos_start) begin
        drive_busy[pos_drive] <= 1'b1;
      end
    end
  end

  // Specify and rate take effect at the write edge; a rate change rescales delays already running.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spec_reg         <= `SPEC_RESET;
      rate_reg         <= `RATE_250K;
      status_reg       <= 4'h0;
      mask_reg         <= 4'h0;
      result_reg       <= 16'h0000;
      result_valid_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (wr_acc && paddr == `OFS_SPECIFY) begin
        spec_reg <= pwdata[15:0];
      end
      if (wr_acc && paddr == `OFS_RATE) begin
        rate_reg <= pwdata[1:0];
      end
      if (wr_acc && paddr == `OFS_MASK) begin
        mask_reg <= pwdata[3:0];
      end
      if (sense_int_cmd) begin
        result_reg       <= {current_cylinder, result_reg_zero};
        result_valid_reg <= 1'b1;
      end else if (sense_drv_cmd) begin
        result_reg       <= {8'h00, drive_status};
        result_valid_reg <= 1'b1;
      end else if (psel && penable && !pwrite && paddr == `OFS_RESULT) begin
        result_valid_reg <= 1'b0;
      end
    end
  end

  // Read data is captured in the setup cycle so the access phase needs no wait.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr)
        `OFS_SPECIFY: prdata <= {16'h0000, spec_reg};
        `OFS_RATE:    prdata <= {30'h00000000, rate_reg};
        `OFS_RESULT:  prdata <= {15'h0000, result_valid_reg, result_reg};
        `OFS_STATUS:  prdata <= {28'h0000000, status_reg};
        `OFS_MASK:    prdata <= {28'h0000000, mask_reg};
        `OFS_STATE:   prdata <= {24'h000000, drive_busy, rw_start_ok, head_load_out,
                                 pend_reg, controller_irq_pin};
        default:      prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // fdc_sense_specify

// [logic/rate_tick.v]
`include "fdc_map.vh"
module rate_tick #(
  parameter BASE_CYC = `BASE_TICK_CYC
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [1:0] rate_sel,
  output reg        tick
);
  reg  [23:0] cnt_reg;
  reg  [23:0] period;

  localparam [31:0] CYC_1M   = BASE_CYC;
  localparam [31:0] CYC_500K = BASE_CYC * 2;
  localparam [31:0] CYC_300K = (BASE_CYC * 10) / 3;
  localparam [31:0] CYC_250K = BASE_CYC * 4;

  // Half a millisecond at the top rate, stretched for slower rates.
  always @* begin
    case (rate_sel)
      `RATE_1M:   period = CYC_1M[23:0];
      `RATE_500K: period = CYC_500K[23:0];
      `RATE_300K: period = CYC_300K[23:0];
      default:    period = CYC_250K[23:0];
    endcase
  end

  // The counter free-runs, so the first step gap may come up short.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 24'h000000;
      tick    <= 1'b0;
    end else if (cnt_reg >= period - 24'h000001) begin
      cnt_reg <= 24'h000000;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 24'h000001;
      tick    <= 1'b0;
    end
  end
endmodule // rate_tick

// [tb/fdc_sense_specify_monitor.sv]
`include "fdc_map.vh"
module fdc_sense_specify_monitor #(
  parameter BASE_CYC = 8
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        rw_result_enter,
  input wire        pos_start,
  input wire        pos_end,
  input wire [1:0]  pos_drive,
  input wire        xfer_byte_req,
  input wire        xfer_byte_done,
  input wire        poll_event,
  input wire        controller_irq_pin,
  input wire        head_load_out,
  input wire        rw_start_ok,
  input wire        step_pulse,
  input wire        non_dma_select,
  input wire [3:0]  drive_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pwrite;
  wire sense_wr = acc && paddr == `OFS_CMD && pwdata[3:0] == `CMD_SENSE_INT;
  wire any_ev = rw_result_enter || pos_end || poll_event || (xfer_byte_req && non_dma_select);
  wire nd_bit = pwdata[`SPEC_ND_BIT];
  property p_rw; rw_result_enter |=> controller_irq_pin; endproperty
  a_rw: assert property (p_rw) else $error("no irq after result entry");
  property p_pos; pos_end |=> controller_irq_pin; endproperty
  a_pos: assert property (p_pos) else $error("no irq after positioning end");
  property p_xfer; xfer_byte_req && non_dma_select && !xfer_byte_done |=> controller_irq_pin; endproperty
  a_xfer: assert property (p_xfer) else $error("no irq on byte request");
  property p_clr; sense_wr && !any_ev |=> !controller_irq_pin; endproperty
  a_clr: assert property (p_clr) else $error("irq not cleared by sense");
  property p_busy; pos_start |=> drive_busy[$past(pos_drive)]; endproperty
  a_busy: assert property (p_busy) else $error("drive not busy");
  property p_step; step_pulse |=> !step_pulse; endproperty
  a_step: assert property (p_step) else $error("step pulse too long");
  property p_load; rw_start_ok |-> head_load_out; endproperty
  a_load: assert property (p_load) else $error("start allowed with head unloaded");
  property p_nd; acc && paddr == `OFS_SPECIFY |=> non_dma_select == $past(nd_bit); endproperty
  a_nd: assert property (p_nd) else $error("transfer mode not loaded");
  property p_hold; controller_irq_pin && !sense_wr && !xfer_byte_done |=> controller_irq_pin; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped early");
endmodule // fdc_sense_specify_monitor

// [tb/host_model.sv]
module host_model (
  input  wire         pclk,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input  wire         pready,
  input  wire  [31:0] prdata,
  input  wire         pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // The request stands until pready is seen high, so a slow slave is served too.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // host_model

// [tb/test_floppy_interrupt_sense_specify.sv]
`include "fdc_map.vh"
module test_floppy_interrupt_sense_specify;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, rw_result_enter = 1'b0, pos_start = 1'b0, pos_end = 1'b0;
  logic pos_abnormal = 1'b0, xfer_byte_req = 1'b0, xfer_byte_done = 1'b0, poll_event = 1'b0;
  logic rw_exec_end = 1'b0, head_load_req = 1'b0, step_request = 1'b0;
  logic [1:0] pos_drive = 2'd0;
  logic [7:0] pos_cylinder = 8'h00, drive_status = 8'ha5;
  wire psel, penable, pwrite, pready, pslverr, controller_irq_pin, irq;
  wire head_load_out, rw_start_ok, step_pulse, non_dma_select;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0] drive_busy;
  logic [31:0] q;
  logic e;
  int err_total = 0, tests_run = 0, cyc = 0, n, k;
  fdc_sense_specify #(.BASE_CYC(8)) fdc_sense_specify_inst (.*);
  host_model host_model_inst (.*);
  initial forever #2 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_model_inst.xfer(1'b1, a, d, q, e);
    #1;
  endtask
  task automatic rd(input logic [11:0] a);
    host_model_inst.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic t_regs();
    rd(`OFS_SPECIFY);
    chk(q, 32'h0);
    rd(`OFS_RATE);
    chk(q, 32'h3);
    rd(`OFS_STATUS);
    chk(q, 32'h0);
    rd(`OFS_MASK);
    chk(q, 32'h0);
    rd(`OFS_STATE);
    chk(q, 32'h0);
    rd(12'h01c);
    chk({31'h0, e}, 32'h1);
  endtask
  task automatic t_pos();
    for (int ab = 0; ab < 2; ab++) begin
      @(posedge pclk);
      pos_drive <= 2'd1;
      pos_start <= 1'b1;
      @(posedge pclk);
      pos_start <= 1'b0;
      pos_end <= 1'b1;
      pos_abnormal <= ab[0];
      pos_cylinder <= 8'h2a;
      @(posedge pclk);
      pos_end <= 1'b0;
      settle();
      chk({31'h0, controller_irq_pin}, 32'h1);
      chk({28'h0, drive_busy}, 32'h2);
      wr(`OFS_CMD, `CMD_SENSE_INT);
      chk({27'h0, drive_busy, controller_irq_pin}, 32'h0);
      rd(`OFS_RESULT);
      chk(q, ab ? 32'h0001_2a61 : 32'h0001_2a21);
    end
  endtask
  task automatic t_poll_rw();
    @(posedge pclk);
    poll_event <= 1'b1;
    @(posedge pclk);
    poll_event <= 1'b0;
    settle();
    wr(`OFS_CMD, `CMD_SENSE_INT);
    rd(`OFS_RESULT);
    chk(q & 32'h0001_00fc, 32'h0001_00c0);
    wr(`OFS_MASK, 32'h1);
    @(posedge pclk);
    rw_result_enter <= 1'b1;
    @(posedge pclk);
    rw_result_enter <= 1'b0;
    repeat (6) @(posedge pclk);
    #1;
    chk({30'h0, irq, controller_irq_pin}, 32'h3);
    wr(`OFS_STATUS, 32'h1);
    chk({30'h0, irq, controller_irq_pin}, 32'h1);
    wr(`OFS_CMD, `CMD_SENSE_INT);
    chk({31'h0, controller_irq_pin}, 32'h0);
    wr(`OFS_MASK, 32'h0);
  endtask
  task automatic t_xfer_drv();
    for (int nd = 0; nd < 2; nd++) begin
      wr(`OFS_SPECIFY, nd << 15);
      chk({31'h0, non_dma_select}, nd);
      @(posedge pclk);
      xfer_byte_req <= 1'b1;
      @(posedge pclk);
      xfer_byte_req <= 1'b0;
      settle();
      chk({31'h0, controller_irq_pin}, nd);
      @(posedge pclk);
      xfer_byte_done <= 1'b1;
      @(posedge pclk);
      xfer_byte_done <= 1'b0;
      settle();
      chk({31'h0, controller_irq_pin}, 32'h0);
    end
    wr(`OFS_CMD, `CMD_SENSE_DRV);
    rd(`OFS_RESULT);
    chk(q & 32'hff, 32'ha5);
  endtask
  task automatic t_delays();
    // The tick runs free and the 300K tick is rounded down, so the bounds carry about a tenth of slack.
    for (int r = 0; r < 4; r++) begin
      k = (r == 0) ? 10 : (r == 1) ? 20 : (r == 2) ? 33 : 40;
      wr(`OFS_RATE, r);
      wr(`OFS_SPECIFY, 32'h0000_0210);
      @(posedge pclk);
      head_load_req <= 1'b1;
      @(posedge pclk);
      head_load_req <= 1'b0;
      for (n = 0; head_load_out !== 1'b1 && n < 100; n++) @(posedge pclk);
      for (n = 0; rw_start_ok !== 1'b1 && n < 5000; n++) @(posedge pclk);
      chk(n >= 21 * k / 10 && n <= 40 * k / 10 + 2, 32'h1);
      @(posedge pclk);
      rw_exec_end <= 1'b1;
      @(posedge pclk);
      rw_exec_end <= 1'b0;
      for (n = 0; head_load_out !== 1'b0 && n < 5000; n++) @(posedge pclk);
      chk(n >= 108 * k / 10 && n <= 136 * k / 10 + 2, 32'h1);
    end
  endtask
  task automatic t_step();
    wr(`OFS_RATE, 32'h0);
    wr(`OFS_SPECIFY, 32'h0000_000e);
    @(posedge pclk);
    step_request <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (step_pulse !== 1'b1 && n < 500);
    end
    chk(n, 32'h10);
    step_request <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_pos();
    t_poll_rw();
    t_xfer_drv();
    t_delays();
    t_step();
    end_sim();
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
endmodule // test_floppy_interrupt_sense_specify
bind fdc_sense_specify fdc_sense_specify_monitor #(.BASE_CYC(BASE_CYC)) fdc_sense_specify_monitor_inst (.*);
